//--- design/wcs_pkg.sv
// Notes on behaviour
// R01: actuator home output follows the upper limit switch input.
// R02: post-pulse delay output high only in the sequencer's afterburst delay state.
// R03: post-pulse active output high only in the sequencer's afterburst state.
// R04: hold state output high only in the sequencer's hold state.
// R05: hold finished output set once hold ends, cleared at next cycle start.
// R06: stack relay select drives one-hot stacks 1-4 or a 4-bit binary code.
// R07: amplitude indicator low for amplitude one, high for amplitude two.
// R08: preset change confirm goes active once a preset is recalled.
// R09: user defined alarm output follows the custom alarm condition.
// R10: cycle pass cleared at cycle start, set at cycle end if no alarm; here only alarms enabled by the mask count.
// R11: cycle start echo high while start active and through weld and hold.
// R12: any alarm output asserts for alarms enabled by a software mask.
// R13: low and high energy alarm outputs follow energy limit violations.
// R14: short and long weld time alarm outputs follow time limit violations.
// R15: low and high peak power alarm outputs follow power limit violations.
// R16: overload alarm output asserts while overload alarm is detected.
// R17: ready high only when idle with no reset-required alarm pending.
// R18: seek or scan output high while seek or horn scan runs.
// R19: sonics active output high while ultrasonic energy is delivered.
// R20: start release output high only when start may be withdrawn.
// R21: a trigger gives one half-second beeper pulse.
// R22: an alarm gives three half-second beeps with half-second gaps; here only alarms enabled by the mask start them.
// R23: cycle complete output high whenever no weld cycle is in process.
// R24: actuator side reports home position on the upper limit switch input.
// R25: beeper timed by a system clock counter; every output registered.
package wcs_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned BEEP_MS = 500;
	localparam int unsigned BEEP_CYCLES = CLK_HZ / 1000 * BEEP_MS;
	localparam int unsigned ALARM_BEEPS = 3;
	localparam int unsigned ALARM_W = 9;
	// alarm vector bit positions
	localparam int unsigned AL_LOW_ENERGY = 0;
	localparam int unsigned AL_HIGH_ENERGY = 1;
	localparam int unsigned AL_SHORT_TIME = 2;
	localparam int unsigned AL_LONG_TIME = 3;
	localparam int unsigned AL_LOW_PEAK = 4;
	localparam int unsigned AL_HIGH_PEAK = 5;
	localparam int unsigned AL_OVERLOAD = 6;
	localparam int unsigned AL_USER = 7;
	localparam int unsigned AL_OTHER = 8;
	localparam logic [ALARM_W-1:0] ALARM_MASK_RST = 9'h1FF;
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;
	localparam int unsigned CTRL_BINARY = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_WELD, SEQ_HOLD, SEQ_AB_DELAY, SEQ_AB, SEQ_OTHER
	} wcs_seq_t;
	typedef enum {BP_IDLE, BP_ON, BP_OFF} wcs_beep_t;
endpackage

//--- design/wcs_status_outputs.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module wcs_status_outputs #(
	parameter int unsigned BEEP_CYCLES = wcs_pkg::BEEP_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// sequencer and process state
	input wire wcs_pkg::wcs_seq_t seq_state,
	input wire logic upper_limit_switch,
	input wire logic start_active,
	input wire logic start_releasable,
	input wire logic cycle_start,
	input wire logic cycle_end,
	input wire logic amp_two_active,
	input wire logic preset_recalled,
	input wire logic [3:0] stack_select,
	input wire logic testing,
	input wire logic scanning,
	input wire logic seeking,
	input wire logic sonics_on,
	input wire logic reset_alarm_pending,
	input wire logic [wcs_pkg::ALARM_W-1:0] alarm_cond,
	input wire logic beep_trigger,
	// status outputs
	output logic actuator_at_home_out,
	output logic post_pulse_delay_out,
	output logic post_pulse_active_out,
	output logic hold_finished_out,
	output logic hold_state_out,
	output logic [3:0] stack_relay_select,
	output logic amplitude_step_indicator,
	output logic preset_change_confirm,
	output logic user_defined_alarm_out,
	output logic cycle_pass_out,
	output logic cycle_start_echo,
	output logic any_alarm_out,
	output logic low_energy_alarm_out,
	output logic high_energy_alarm_out,
	output logic short_time_alarm_out,
	output logic long_time_alarm_out,
	output logic low_peak_alarm_out,
	output logic high_peak_alarm_out,
	output logic overload_alarm_out,
	output logic system_ready_out,
	output logic seek_or_scan_out,
	output logic sonics_active_out,
	output logic start_release_out,
	output logic beeper_drive_out,
	output logic cycle_complete_out,
	// axi4-lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int unsigned AW = wcs_pkg::ALARM_W;

	// the beep counter is 32 bits wide and must count at least one cycle
	if (BEEP_CYCLES < 1 || BEEP_CYCLES > 32'h7FFFFFFF) begin : g_bad_beep
		$error("BEEP_CYCLES out of range");
	end

	typedef struct packed {
		logic [25:0] outs;
		logic [3:0] relay;
		logic in_cycle;
		logic cycle_alarm;
		logic hold_seen;
		logic confirm;
		logic pass;
		logic echo;
		logic [AW-1:0] alarm_prev;
		wcs_pkg::wcs_beep_t beep;
		logic [31:0] beep_cnt;
		logic [1:0] beeps_left;
		logic binary_mode;
		logic [AW-1:0] mask;
		logic aw_got;
		logic w_got;
		logic [3:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} wcs_state_t;

	wcs_state_t st_ff;
	wcs_state_t nxt_st;

	function automatic logic [3:0] relay_code(input logic [3:0] sel, input logic binary);
		logic [3:0] r;
		r = 4'h0;
		if (binary) begin
			r = sel;
		end else if (sel < 4'h4) begin
			r = 4'(4'h1 << sel[1:0]);
		end
		return r;
	endfunction

	// registers answer only on their own aligned byte address
	function automatic logic reg_mapped(input logic [3:0] addr);
		return addr == wcs_pkg::REG_CTRL || addr == wcs_pkg::REG_MASK
			|| addr == wcs_pkg::REG_STAT;
	endfunction

	logic [AW-1:0] alarm_rise;
	logic any_alarm;
	logic do_write;
	logic [31:0] wr_merged;
	logic [31:0] rd_word;

	assign alarm_rise = alarm_cond & ~st_ff.alarm_prev;
	assign any_alarm = |(alarm_cond & st_ff.mask); // [R12]
	assign do_write = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;

	always_comb begin
		wr_merged = 32'h0;
		for (int i = 0; i < 4; i++) begin
			wr_merged[i*8 +: 8] = st_ff.wstrb[i] ? st_ff.wdata[i*8 +: 8] : 8'h0;
		end
	end

	always_comb begin
		rd_word = 32'h0;
		case (s_axi_araddr)
			wcs_pkg::REG_CTRL: rd_word[wcs_pkg::CTRL_BINARY] = st_ff.binary_mode;
			wcs_pkg::REG_MASK: rd_word[AW-1:0] = st_ff.mask;
			wcs_pkg::REG_STAT: rd_word[AW-1:0] = alarm_cond;
			default: rd_word = 32'h0;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.alarm_prev = alarm_cond;

		// cycle tracking
		if (cycle_start) begin
			nxt_st.in_cycle = 1'b1;
			nxt_st.cycle_alarm = 1'b0;
			nxt_st.hold_seen = 1'b0; // [R05]
			nxt_st.pass = 1'b0; // [R10]
			nxt_st.confirm = 1'b0;
		end else begin
			if (any_alarm) begin
				nxt_st.cycle_alarm = 1'b1;
			end
			if (st_ff.in_cycle && seq_state != wcs_pkg::SEQ_HOLD
					&& st_ff.outs[4]) begin
				nxt_st.hold_seen = 1'b1; // [R05]
			end
			if (cycle_end && st_ff.in_cycle) begin
				nxt_st.in_cycle = 1'b0;
			end
		end
		// a cycle that ends as the next one starts still reports its verdict
		if (cycle_end && st_ff.in_cycle) begin
			nxt_st.pass = !(st_ff.cycle_alarm || any_alarm); // [R10]
		end
		if (preset_recalled) begin
			nxt_st.confirm = 1'b1; // [R08]
		end
		nxt_st.echo = start_active || seq_state == wcs_pkg::SEQ_WELD
			|| seq_state == wcs_pkg::SEQ_HOLD; // [R11]

		// beeper pattern, alarm request overrides a single beep
		if (alarm_rise != '0 && (alarm_rise & st_ff.mask) != '0) begin
			nxt_st.beep = wcs_pkg::BP_ON; // [R22]
			nxt_st.beep_cnt = 32'(BEEP_CYCLES - 1);
			nxt_st.beeps_left = 2'(wcs_pkg::ALARM_BEEPS - 1);
		end else if (beep_trigger && st_ff.beep == wcs_pkg::BP_IDLE) begin
			nxt_st.beep = wcs_pkg::BP_ON; // [R21]
			nxt_st.beep_cnt = 32'(BEEP_CYCLES - 1);
			nxt_st.beeps_left = 2'h0;
		end else begin
			case (st_ff.beep)
				wcs_pkg::BP_IDLE: nxt_st.beep = wcs_pkg::BP_IDLE;
				wcs_pkg::BP_ON: begin
					if (st_ff.beep_cnt != 32'h0) begin
						nxt_st.beep_cnt = st_ff.beep_cnt - 32'h1; // [R25]
					end else if (st_ff.beeps_left != 2'h0) begin
						nxt_st.beep = wcs_pkg::BP_OFF; // [R22]
						nxt_st.beep_cnt = 32'(BEEP_CYCLES - 1);
					end else begin
						nxt_st.beep = wcs_pkg::BP_IDLE;
					end
				end
				wcs_pkg::BP_OFF: begin
					if (st_ff.beep_cnt != 32'h0) begin
						nxt_st.beep_cnt = st_ff.beep_cnt - 32'h1;
					end else begin
						nxt_st.beep = wcs_pkg::BP_ON;
						nxt_st.beep_cnt = 32'(BEEP_CYCLES - 1);
						nxt_st.beeps_left = st_ff.beeps_left - 2'h1;
					end
				end
				default: nxt_st.beep = wcs_pkg::BP_IDLE;
			endcase
		end

		// registered outputs
		nxt_st.outs[0] = upper_limit_switch; // [R01]
		nxt_st.outs[1] = seq_state == wcs_pkg::SEQ_AB_DELAY; // [R02]
		nxt_st.outs[2] = seq_state == wcs_pkg::SEQ_AB; // [R03]
		nxt_st.outs[4] = seq_state == wcs_pkg::SEQ_HOLD; // [R04]
		nxt_st.outs[3] = nxt_st.hold_seen;
		nxt_st.outs[5] = amp_two_active; // [R07]
		nxt_st.outs[6] = nxt_st.confirm;
		nxt_st.outs[7] = alarm_cond[wcs_pkg::AL_USER]; // [R09]
		nxt_st.outs[8] = nxt_st.pass;
		nxt_st.outs[9] = nxt_st.echo;
		nxt_st.outs[10] = any_alarm;
		nxt_st.outs[11] = alarm_cond[wcs_pkg::AL_LOW_ENERGY]; // [R13]
		nxt_st.outs[12] = alarm_cond[wcs_pkg::AL_HIGH_ENERGY]; // [R13]
		nxt_st.outs[13] = alarm_cond[wcs_pkg::AL_SHORT_TIME]; // [R14]
		nxt_st.outs[14] = alarm_cond[wcs_pkg::AL_LONG_TIME]; // [R14]
		nxt_st.outs[15] = alarm_cond[wcs_pkg::AL_LOW_PEAK]; // [R15]
		nxt_st.outs[16] = alarm_cond[wcs_pkg::AL_HIGH_PEAK]; // [R15]
		nxt_st.outs[17] = alarm_cond[wcs_pkg::AL_OVERLOAD]; // [R16]
		nxt_st.outs[18] = !nxt_st.in_cycle && !testing && !scanning
			&& !reset_alarm_pending && seq_state == wcs_pkg::SEQ_IDLE; // [R17]
		nxt_st.outs[19] = seeking || scanning; // [R18]
		nxt_st.outs[20] = sonics_on; // [R19]
		nxt_st.outs[21] = start_active && start_releasable; // [R20]
		nxt_st.outs[22] = nxt_st.beep == wcs_pkg::BP_ON; // [R25]
		nxt_st.outs[23] = !nxt_st.in_cycle; // [R23]
		nxt_st.outs[25:24] = 2'h0;
		nxt_st.relay = relay_code(stack_select, st_ff.binary_mode); // [R06]

		// axi4-lite slave
		if (s_axi_awvalid && !st_ff.aw_got) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.w_got) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wcs_pkg::RESP_OKAY;
			case (st_ff.awaddr)
				wcs_pkg::REG_CTRL: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.binary_mode = wr_merged[wcs_pkg::CTRL_BINARY];
					end
				end
				wcs_pkg::REG_MASK: begin
					// byte 0 holds mask bits 7:0, byte 1 holds bit 8
					nxt_st.mask = (st_ff.mask & ~{st_ff.wstrb[1], {8{st_ff.wstrb[0]}}})
						| wr_merged[AW-1:0]; // [R12]
				end
				default: nxt_st.bresp = reg_mapped(st_ff.awaddr)
					? wcs_pkg::RESP_OKAY : wcs_pkg::RESP_SLVERR;
			endcase
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
		end
		if (s_axi_arvalid && !st_ff.rvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_word;
			nxt_st.rresp = reg_mapped(s_axi_araddr)
				? wcs_pkg::RESP_OKAY : wcs_pkg::RESP_SLVERR;
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '{mask: wcs_pkg::ALARM_MASK_RST, beep: wcs_pkg::BP_IDLE,
				outs: 26'h0800000, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign actuator_at_home_out = st_ff.outs[0];
	assign post_pulse_delay_out = st_ff.outs[1];
	assign post_pulse_active_out = st_ff.outs[2];
	assign hold_finished_out = st_ff.outs[3];
	assign hold_state_out = st_ff.outs[4];
	assign amplitude_step_indicator = st_ff.outs[5];
	assign preset_change_confirm = st_ff.outs[6];
	assign user_defined_alarm_out = st_ff.outs[7];
	assign cycle_pass_out = st_ff.outs[8];
	assign cycle_start_echo = st_ff.outs[9];
	assign any_alarm_out = st_ff.outs[10];
	assign low_energy_alarm_out = st_ff.outs[11];
	assign high_energy_alarm_out = st_ff.outs[12];
	assign short_time_alarm_out = st_ff.outs[13];
	assign long_time_alarm_out = st_ff.outs[14];
	assign low_peak_alarm_out = st_ff.outs[15];
	assign high_peak_alarm_out = st_ff.outs[16];
	assign overload_alarm_out = st_ff.outs[17];
	assign system_ready_out = st_ff.outs[18];
	assign seek_or_scan_out = st_ff.outs[19];
	assign sonics_active_out = st_ff.outs[20];
	assign start_release_out = st_ff.outs[21];
	assign beeper_drive_out = st_ff.outs[22];
	assign cycle_complete_out = st_ff.outs[23];
	assign stack_relay_select = st_ff.relay;
	assign s_axi_awready = !st_ff.aw_got;
	assign s_axi_wready = !st_ff.w_got;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = !st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
endmodule

//--- sim/wcs_status_checker.sv
`timescale 1ns/1ns
module wcs_status_checker #(
	parameter int unsigned BEEP_CYCLES = wcs_pkg::BEEP_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// inputs
	input wire wcs_pkg::wcs_seq_t seq_state,
	input wire logic upper_limit_switch,
	input wire logic start_active,
	input wire logic cycle_start,
	input wire logic cycle_end,
	input wire logic testing,
	input wire logic scanning,
	input wire logic reset_alarm_pending,
	input wire logic [wcs_pkg::ALARM_W-1:0] alarm_cond,
	// outputs
	input wire logic actuator_at_home_out,
	input wire logic post_pulse_delay_out,
	input wire logic post_pulse_active_out,
	input wire logic hold_state_out,
	input wire logic cycle_pass_out,
	input wire logic cycle_start_echo,
	input wire logic user_defined_alarm_out,
	input wire logic overload_alarm_out,
	input wire logic system_ready_out,
	input wire logic beeper_drive_out,
	input wire logic cycle_complete_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [31:0] on_cnt_ff;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			on_cnt_ff <= 32'h0;
		end else begin
			on_cnt_ff <= beeper_drive_out ? on_cnt_ff + 32'h1 : 32'h0;
		end
	end
	sequence s_cycle_open;
		cycle_start && !cycle_end;
	endsequence
	sequence s_clean_end;
		cycle_end && !cycle_start;
	endsequence
	AST_HOME: assert property (actuator_at_home_out == $past(upper_limit_switch))
		else $error("actuator home does not follow limit switch");
	AST_SEQ: assert property ({post_pulse_delay_out, post_pulse_active_out,
		hold_state_out} == {$past(seq_state) == wcs_pkg::SEQ_AB_DELAY,
		$past(seq_state) == wcs_pkg::SEQ_AB, $past(seq_state) == wcs_pkg::SEQ_HOLD})
		else $error("state outputs wrong");
	AST_PASS_CLR: assert property (s_cycle_open |=>
		!cycle_pass_out && !cycle_complete_out)
		else $error("cycle start did not clear pass or complete");
	AST_PASS_SET: assert property ($rose(cycle_pass_out) |-> $past(cycle_end))
		else $error("pass rose without cycle end");
	AST_COMPLETE: assert property (s_clean_end |=> cycle_complete_out)
		else $error("complete not set after cycle end");
	AST_ECHO: assert property (start_active |=> cycle_start_echo)
		else $error("start echo missing");
	AST_READY: assert property (system_ready_out |->
		$past(seq_state) == wcs_pkg::SEQ_IDLE && !$past(testing) && !$past(scanning) &&
		!$past(reset_alarm_pending)) else $error("ready while busy");
	AST_ALARM: assert property ({user_defined_alarm_out, overload_alarm_out} ==
		$past(alarm_cond[7:6])) else $error("alarm outputs wrong");
	AST_BEEP: assert property ($fell(beeper_drive_out) |->
		on_cnt_ff >= BEEP_CYCLES) else $error("beep too short");
endmodule

//--- sim/wcs_ctrl_model.sv
`timescale 1ns/1ns
// controller side: only reads the beeper line and measures its pattern
module wcs_ctrl_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// observed line and pulse count clear
	input wire logic beeper_drive_out,
	input wire logic clear,
	// measurements
	output logic [7:0] pulses,
	output logic [31:0] on_len,
	output logic [31:0] off_len
);
	logic [31:0] run_ff;
	logic last_ff;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			{pulses, on_len, off_len, run_ff, last_ff} <= '0;
		end else begin
			last_ff <= beeper_drive_out;
			run_ff <= (beeper_drive_out != last_ff) ? 32'h1 : run_ff + 32'h1;
			if (beeper_drive_out != last_ff && last_ff) on_len <= run_ff;
			if (beeper_drive_out && !last_ff && pulses != 8'h0) off_len <= run_ff;
			if (clear) pulses <= 8'h0;
			else if (beeper_drive_out && !last_ff) pulses <= pulses + 8'h1;
		end
	end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	localparam int unsigned BC = 6;
	logic clk_sys = '0, arst_n = '0, clr = '0, mode = '0;
	wcs_pkg::wcs_seq_t seq_state = wcs_pkg::SEQ_IDLE;
	logic upper_limit_switch = '0, start_active = '0, start_releasable = '0, cycle_start = '0;
	logic cycle_end = '0, amp_two_active = '0, preset_recalled = '0, testing = '0, scanning = '0;
	logic seeking = '0, sonics_on = '0, reset_alarm_pending = '0, beep_trigger = '0;
	logic [3:0] stack_select = '0, s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = '0, rd, s_axi_rdata, on_len, off_len;
	logic [8:0] alarm_cond = '0, mask = 9'h1FF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
	logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0] pulses;
	logic [22:0] lv_exp, lv_seen;
	logic [3:0] stack_relay_select;
	logic actuator_at_home_out, post_pulse_delay_out, post_pulse_active_out, hold_finished_out;
	logic hold_state_out, amplitude_step_indicator, preset_change_confirm, user_defined_alarm_out;
	logic cycle_pass_out, cycle_start_echo, any_alarm_out, low_energy_alarm_out, sonics_active_out;
	logic high_energy_alarm_out, short_time_alarm_out, long_time_alarm_out, low_peak_alarm_out;
	logic high_peak_alarm_out, overload_alarm_out, system_ready_out, seek_or_scan_out;
	logic start_release_out, beeper_drive_out, cycle_complete_out;
	int fails = 0, num_checks = 0, seed;
	wcs_status_outputs #(.BEEP_CYCLES(BC)) dut (.*);
	wcs_ctrl_model model (.clk_sys, .arst_n, .beeper_drive_out, .clear(clr), .pulses, .on_len,
		.off_len);
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	function automatic logic [22:0] exp_lv();
		logic [3:0] rel;
		rel = mode ? stack_select : (stack_select < 4 ? 4'h1 << stack_select : 4'h0);
		return {upper_limit_switch, seq_state == wcs_pkg::SEQ_AB_DELAY, seq_state == wcs_pkg::SEQ_AB,
			seq_state == wcs_pkg::SEQ_HOLD, amp_two_active,
			start_active || seq_state == wcs_pkg::SEQ_WELD || seq_state == wcs_pkg::SEQ_HOLD,
			seq_state == wcs_pkg::SEQ_IDLE && !testing && !scanning && !reset_alarm_pending,
			seeking || scanning, sonics_on, start_active && start_releasable, alarm_cond[7:0],
			|(alarm_cond & mask), rel};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		logic ak, wk, rk, done;
		done = 0;
		@(posedge clk_sys);
		if (wr) begin
			{s_axi_awaddr, s_axi_wdata} <= {a, d};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		end else begin
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
		end
		for (int i = 0; i < 40 && !done; i++) begin
			@(negedge clk_sys);
			ak = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
			wk = s_axi_wvalid && s_axi_wready;
			rk = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge clk_sys);
			if (ak && wr) s_axi_awvalid <= 0;
			if (ak && !wr) s_axi_arvalid <= 0;
			if (wk) s_axi_wvalid <= 0;
			if (rk) {s_axi_bready, s_axi_rready} <= 2'h0;
			done = rk;
		end
		if (!done) begin
			chk("axi_timeout", 32'h1, 32'h0);
			results();
		end
	endtask
	initial begin
		seed = $urandom(32'h6ACD);
		repeat (2) @(posedge clk_sys);
		chk("complete_rst", 32'h1, cycle_complete_out);
		arst_n <= 1;
		axi(0, wcs_pkg::REG_CTRL, 0, rd, rsp);
		chk("ctrl_rst", 32'h0, rd);
		axi(0, wcs_pkg::REG_MASK, 0, rd, rsp);
		chk("mask_rst", 32'h1FF, rd);
		axi(0, 4'hC, 0, rd, rsp);
		chk("unmapped", 32'h2, {rd[29:0], rsp});
		axi(1, wcs_pkg::REG_STAT, 32'h1FF, rd, rsp);
		chk("stat_wr", 32'h0, rsp);
		for (int p = 0; p < 2; p++) begin
			mode = p[0];
			mask = p ? 9'($urandom) : 9'h1FF;
			axi(1, wcs_pkg::REG_CTRL, {31'h0, mode}, rd, rsp);
			axi(1, wcs_pkg::REG_MASK, {23'h0, mask}, rd, rsp);
			for (int i = 0; i < 30; i++) begin
				@(posedge clk_sys);
				seq_state <= wcs_pkg::wcs_seq_t'(i % 4 == 0 ? 0 : $urandom % 6);
				{upper_limit_switch, start_active, start_releasable, amp_two_active, testing, scanning,
					seeking, sonics_on, reset_alarm_pending} <= i % 4 == 0 ? 9'h0 : 9'($urandom);
				alarm_cond <= 9'($urandom);
				stack_select <= 4'($urandom);
				@(posedge clk_sys);
				@(negedge clk_sys);
				lv_exp = exp_lv();
				lv_seen = {actuator_at_home_out, post_pulse_delay_out, post_pulse_active_out,
					hold_state_out, amplitude_step_indicator, cycle_start_echo, system_ready_out,
					seek_or_scan_out, sonics_active_out, start_release_out, user_defined_alarm_out,
					overload_alarm_out, high_peak_alarm_out, low_peak_alarm_out, long_time_alarm_out,
					short_time_alarm_out, high_energy_alarm_out, low_energy_alarm_out, any_alarm_out,
					stack_relay_select};
				chk("home_seq", lv_exp[22:19], lv_seen[22:19]);
				chk("amp_echo", lv_exp[18:17], lv_seen[18:17]);
				chk("ready_misc", lv_exp[16:13], lv_seen[16:13]);
				chk("alarms", lv_exp[12:4], lv_seen[12:4]);
				chk("relay", lv_exp[3:0], lv_seen[3:0]);
			end
			axi(0, wcs_pkg::REG_STAT, 0, rd, rsp);
			chk("stat", alarm_cond, rd);
		end
		mask = 9'h1FF;
		axi(1, wcs_pkg::REG_MASK, 32'h1FF, rd, rsp);
		seq_state <= wcs_pkg::SEQ_IDLE;
		{alarm_cond, upper_limit_switch, start_active, testing, scanning, reset_alarm_pending} <= '0;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			preset_recalled <= 1;
			@(posedge clk_sys);
			preset_recalled <= 0;
			@(negedge clk_sys);
			chk("confirm", 32'h1, preset_change_confirm);
			@(posedge clk_sys);
			seq_state <= wcs_pkg::SEQ_WELD;
			cycle_start <= 1'b1;
			alarm_cond <= k ? 9'h040 : 9'h0;
			@(posedge clk_sys);
			seq_state <= wcs_pkg::SEQ_HOLD;
			cycle_start <= 1'b0;
			@(negedge clk_sys);
			chk("open_pass", 32'h0, {cycle_pass_out, cycle_complete_out});
			chk("open_other", 32'h0, {preset_change_confirm, hold_finished_out,
				system_ready_out});
			@(posedge clk_sys);
			seq_state <= wcs_pkg::SEQ_IDLE;
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("hold_end", 32'h1, hold_finished_out);
			@(posedge clk_sys);
			cycle_end <= 1;
			@(posedge clk_sys);
			{cycle_end, alarm_cond} <= '0;
			@(negedge clk_sys);
			chk("cycle_end", {k == 0, 1'b1}, {cycle_pass_out, cycle_complete_out});
		end
		repeat (60) @(posedge clk_sys);
		{clr, beep_trigger} <= 2'h3;
		@(posedge clk_sys);
		{clr, beep_trigger} <= 2'h0;
		repeat (3 * BC) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("one_beep", {8'h1, 24'(BC)}, {pulses, on_len[23:0]});
		@(posedge clk_sys);
		alarm_cond <= 9'h001;
		repeat (8 * BC) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("alarm_beeps", {8'h4, 24'(BC)}, {pulses, on_len[23:0]});
		chk("alarm_gap", BC, off_len);
		results();
	end
endmodule
bind wcs_status_outputs wcs_status_checker #(.BEEP_CYCLES(BEEP_CYCLES)) chk_i (
	.clk_sys, .arst_n, .seq_state, .upper_limit_switch, .start_active, .cycle_start,
	.cycle_end, .testing, .scanning, .reset_alarm_pending, .alarm_cond,
	.actuator_at_home_out, .post_pulse_delay_out, .post_pulse_active_out, .hold_state_out,
	.cycle_pass_out, .cycle_start_echo, .user_defined_alarm_out, .overload_alarm_out,
	.system_ready_out, .beeper_drive_out, .cycle_complete_out);
